// >>> verif/dcf_event_flags_tb.sv
// self-checking bench for the channel 5/6 event flag bank
// assumes the bench is bus master and transfer engine on sys_clk
`timescale 1ns/10ps
module testbench
    import dcf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    dcf_bus_req_t bus_req = '0;
    logic [DCF_DATA_W-1:0] rd_data;
    dcf_ch5_ev_t ch5_ev = '0;
    dcf_ch6_ev_t ch6_ev = '0;
    logic [DCF_NUM_FLAGS-1:0] flags_out;
    logic [DCF_DATA_W-1:0] d;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    dcf_event_flags uut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
        .rd_data(rd_data), .ch5_ev(ch5_ev), .ch6_ev(ch6_ev),
        .flags_out(flags_out));

    always #4 sys_clk = ~sys_clk;

    task automatic stop_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // whole run is about 65 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            $display("Error %0t: run did not finish", $time);
            stop_test();
        end
    end

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_fl(input logic [5:0] exp);
        n_tests++;
        if (flags_out !== exp) begin
            n_mismatch++;
            $display("Error %0t: flags %h expected %h", $time, flags_out, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    // data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 v = rd_data;
    endtask

    // v = {ch5 half, ch5 error, ch6 done, ch6 half, ch6 error}
    task automatic ev(input logic [4:0] v);
        @(posedge sys_clk);
        {ch5_ev, ch6_ev} <= v;
        @(posedge sys_clk);
        {ch5_ev, ch6_ev} <= 5'h00;
        #1;
    endtask

    task automatic t_reset();
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk_fl(6'h00);
        bus_rd(DCF_STATUS_OFF, d);
        chk_rd(d, 32'h0000_0000);
        $display("reset test done");
    endtask

    task automatic t_events();
        ev(5'h10);
        chk_fl(6'h01);
        ev(5'h08);
        chk_fl(6'h03);
        ev(5'h04);
        chk_fl(6'h0f);
        bus_wr(DCF_CLEAR_OFF, 32'h1 << DCF_CH6_ALL_CLR_BIT);
        ev(5'h02);
        chk_fl(6'h17);
        bus_wr(DCF_CLEAR_OFF, 32'h1 << DCF_CH6_ALL_CLR_BIT);
        ev(5'h01);
        chk_fl(6'h27);
        bus_rd(DCF_STATUS_OFF, d);
        chk_rd(d, 32'h09c0_0000);
        $display("event test done");
    endtask

    task automatic t_clear();
        bus_wr(DCF_STATUS_OFF, 32'hffff_ffff);
        chk_fl(6'h27);
        bus_wr(DCF_CLEAR_OFF, 32'h0000_0000);
        chk_fl(6'h27);
        bus_wr(DCF_CLEAR_OFF, 32'h1 << DCF_CH6_ERR_BIT);
        chk_fl(6'h07);
        bus_wr(DCF_CLEAR_OFF, 32'h1 << DCF_CH5_ALL_CLR_BIT);
        chk_fl(6'h04);
        bus_wr(DCF_CLEAR_OFF, 32'h1 << DCF_CH6_ALL_CLR_BIT);
        chk_fl(6'h00);
        $display("clear test done");
    endtask

    task automatic t_decode();
        ev(5'h1f);
        chk_fl(6'h3f);
        bus_rd(DCF_CLEAR_OFF, d);
        chk_rd(d, 32'h0000_0000);
        bus_rd(8'h08, d);
        chk_rd(d, 32'h0000_0000);
        bus_wr(8'h08, 32'hffff_ffff);
        chk_fl(6'h3f);
        bus_rd(DCF_STATUS_OFF, d);
        chk_rd(d, 32'h0fc0_0000);
        @(posedge sys_clk);
        #1 chk_rd(rd_data, 32'h0000_0000);
        bus_wr(DCF_CLEAR_OFF, 32'h0110_0000);
        chk_fl(6'h00);
        $display("decode test done");
    endtask

    // set and clear in one cycle: every event must survive
    task automatic t_race();
        ev(5'h12);
        chk_fl(6'h15);
        @(posedge sys_clk);
        ch5_ev <= '{half: 1'b1, error: 1'b0};
        ch6_ev <= '{done: 1'b1, half: 1'b0, error: 1'b1};
        bus_req <= '{addr: DCF_CLEAR_OFF, wdata: 32'h0140_0000,
            wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        ch5_ev <= '0;
        ch6_ev <= '0;
        bus_req.wr <= 1'b0;
        #1 chk_fl(6'h2d);
        // event then status read with no gap between them
        @(posedge sys_clk);
        ch5_ev <= '{half: 1'b0, error: 1'b1};
        @(posedge sys_clk);
        ch5_ev <= '0;
        bus_req <= '{addr: DCF_STATUS_OFF, wdata: 32'h0, wr: 1'b0,
            rd: 1'b1};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 chk_rd(rd_data, 32'h0bc0_0000);
        ev(5'h1f);
        $display("race test done");
    endtask

    initial begin
        t_reset();
        t_events();
        t_clear();
        t_decode();
        t_race();
        t_reset();
        stop_test();
    end
endmodule

// >>> verilog/dcf_event_flags.sv
// event flag bank for DMA channels 5 and 6 with its status/clear port
// assumes event strobes are one-cycle pulses from the transfer engine on
// sys_clk, and a bus master that never asserts rd and wr together
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module dcf_event_flags
    import dcf_pkg::*;
(
    input logic sys_clk,
    input logic rst,
    input dcf_bus_req_t bus_req,
    output logic [DCF_DATA_W-1:0] rd_data,
    input dcf_ch5_ev_t ch5_ev,
    input dcf_ch6_ev_t ch6_ev,
    output logic [DCF_NUM_FLAGS-1:0] flags_out
);

    function automatic logic dcf_hit(
        input logic [DCF_ADDR_W-1:0] addr,
        input logic [DCF_ADDR_W-1:0] off
    );
        dcf_hit = (addr == off);
    endfunction

    // flag vector index 0..5 maps onto status bits 22..27
    localparam int IDX_CH5_HALF = DCF_CH5_HALF_BIT - DCF_CH5_HALF_BIT;
    localparam int IDX_CH5_ERR = DCF_CH5_ERR_BIT - DCF_CH5_HALF_BIT;
    localparam int IDX_CH6_ANY = DCF_CH6_ANY_BIT - DCF_CH5_HALF_BIT;
    localparam int IDX_CH6_DONE = DCF_CH6_DONE_BIT - DCF_CH5_HALF_BIT;
    localparam int IDX_CH6_HALF = DCF_CH6_HALF_BIT - DCF_CH5_HALF_BIT;
    localparam int IDX_CH6_ERR = DCF_CH6_ERR_BIT - DCF_CH5_HALF_BIT;

    wire status_hit;
    wire clear_hit;
    wire clear_wr;
    wire ch5_all_clr;
    wire ch6_all_clr;
    wire ch6_any_ev;
    wire [DCF_NUM_FLAGS-1:0] set_vec;
    wire [DCF_NUM_FLAGS-1:0] clr_vec;
    wire [DCF_NUM_FLAGS-1:0] flags;
    wire [DCF_DATA_W-1:0] status_word;
    wire [DCF_DATA_W-1:0] rd_data_next;

    logic [DCF_DATA_W-1:0] rd_data_reg;

    assign status_hit = dcf_hit(bus_req.addr, DCF_STATUS_OFF);
    assign clear_hit = dcf_hit(bus_req.addr, DCF_CLEAR_OFF);

    // writes to the status word are dropped: flags are read-only
    assign clear_wr = bus_req.wr && clear_hit;
    assign ch5_all_clr = clear_wr && bus_req.wdata[DCF_CH5_ALL_CLR_BIT];
    assign ch6_all_clr = clear_wr && bus_req.wdata[DCF_CH6_ALL_CLR_BIT];

    assign ch6_any_ev = ch6_ev.error || ch6_ev.half || ch6_ev.done;

    assign set_vec[IDX_CH5_HALF] = ch5_ev.half;
    assign set_vec[IDX_CH5_ERR] = ch5_ev.error;
    assign set_vec[IDX_CH6_ANY] = ch6_any_ev;
    assign set_vec[IDX_CH6_DONE] = ch6_ev.done;
    assign set_vec[IDX_CH6_HALF] = ch6_ev.half;
    assign set_vec[IDX_CH6_ERR] = ch6_ev.error;

    // only a written one clears; a zero leaves the flag alone
    assign clr_vec[IDX_CH5_HALF] = ch5_all_clr ||
        (clear_wr && bus_req.wdata[DCF_CH5_HALF_BIT]);
    assign clr_vec[IDX_CH5_ERR] = ch5_all_clr ||
        (clear_wr && bus_req.wdata[DCF_CH5_ERR_BIT]);
    assign clr_vec[IDX_CH6_ANY] = ch6_all_clr;
    assign clr_vec[IDX_CH6_DONE] = ch6_all_clr ||
        (clear_wr && bus_req.wdata[DCF_CH6_DONE_BIT]);
    assign clr_vec[IDX_CH6_HALF] = ch6_all_clr ||
        (clear_wr && bus_req.wdata[DCF_CH6_HALF_BIT]);
    assign clr_vec[IDX_CH6_ERR] = ch6_all_clr ||
        (clear_wr && bus_req.wdata[DCF_CH6_ERR_BIT]);

    genvar gi;
    generate
        for (gi = 0; gi < DCF_NUM_FLAGS; gi++) begin : g_flag
            dcf_flag_cell u_cell (
                .sys_clk(sys_clk),
                .rst(rst),
                .set(set_vec[gi]),
                .clr(clr_vec[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    // other channels' bits live elsewhere and read zero here
    assign status_word = {
        {(DCF_DATA_W - DCF_CH6_ERR_BIT - 1){1'b0}},
        flags,
        {DCF_CH5_HALF_BIT{1'b0}}
    };

    // clear register is write-only and unmapped offsets read zero
    assign rd_data_next = (bus_req.rd && status_hit) ? status_word :
        DCF_RDATA_RST;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= DCF_RDATA_RST;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign flags_out = flags;

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_status_read;
        bus_req.rd && dcf_hit(bus_req.addr, DCF_STATUS_OFF);
    endsequence

    sequence s_ch6_all_clear;
        bus_req.wr && dcf_hit(bus_req.addr, DCF_CLEAR_OFF) &&
            bus_req.wdata[DCF_CH6_ALL_CLR_BIT];
    endsequence

    sequence s_ch5_half_clear;
        bus_req.wr && dcf_hit(bus_req.addr, DCF_CLEAR_OFF) &&
            bus_req.wdata[DCF_CH5_HALF_BIT];
    endsequence

    a_ch5_half_seen: assert property (
        ch5_ev.half |=> flags_out[IDX_CH5_HALF]
    ) else $error("ch5 half event not recorded");

    a_ch5_err_read: assert property (
        ch5_ev.error ##1 s_status_read |=> rd_data[DCF_CH5_ERR_BIT] ||
            $past(clr_vec[IDX_CH5_ERR])
    ) else $error("ch5 error flag not visible on read");

    a_ch6_any_set: assert property (
        (ch6_ev.error || ch6_ev.half || ch6_ev.done) |=>
            flags_out[IDX_CH6_ANY]
    ) else $error("ch6 any-event flag missed an event");

    a_ch6_done_set: assert property (
        ch6_ev.done |=> flags_out[IDX_CH6_DONE] && flags_out[IDX_CH6_ANY]
    ) else $error("ch6 done flag not set");

    a_ch6_half_set: assert property (
        ch6_ev.half |=> flags_out[IDX_CH6_HALF] && flags_out[IDX_CH6_ANY]
    ) else $error("ch6 half flag not set");

    a_ch6_err_read: assert property (
        s_status_read |=> rd_data[DCF_CH6_ERR_BIT] ==
            $past(flags_out[IDX_CH6_ERR])
    ) else $error("ch6 error flag misplaced in status word");

    a_flag_no_selfclear: assert property (
        flags_out[IDX_CH6_DONE] && !clr_vec[IDX_CH6_DONE] |=>
            flags_out[IDX_CH6_DONE]
    ) else $error("ch6 done flag cleared without a write");

    a_status_wr_ignored: assert property (
        bus_req.wr && dcf_hit(bus_req.addr, DCF_STATUS_OFF) &&
            flags_out[IDX_CH5_ERR] |=> flags_out[IDX_CH5_ERR]
    ) else $error("write to status word changed a flag");

    a_ch6_all_clear: assert property (
        s_ch6_all_clear ##0 !(ch6_ev.error || ch6_ev.half || ch6_ev.done)
            |=> flags_out[IDX_CH6_ERR:IDX_CH6_ANY] == 4'h0
    ) else $error("ch6 all-flags clear left a flag set");

    a_unmapped_read: assert property (
        bus_req.rd && !dcf_hit(bus_req.addr, DCF_STATUS_OFF) |=>
            rd_data == DCF_RDATA_RST
    ) else $error("unmapped or clear-register read not zero");

    a_set_beats_clear: assert property (
        s_ch5_half_clear ##0 ch5_ev.half |=> flags_out[IDX_CH5_HALF]
    ) else $error("event lost against a same-cycle clear");

    a_ch6_set_beats_all: assert property (
        s_ch6_all_clear ##0 ch6_ev.error |=>
            flags_out[IDX_CH6_ERR] && flags_out[IDX_CH6_ANY]
            ##1 flags_out[IDX_CH6_ERR] || $past(clr_vec[IDX_CH6_ERR])
    ) else $error("ch6 error lost against all-flags clear");

endmodule

// >>> verilog/dcf_flag_cell.sv
// one sticky event flag: hardware sets, software clears
// assumes set and clear come from logic on sys_clk
`timescale 1ns/10ps
module dcf_flag_cell
    import dcf_pkg::*;
(
    input logic sys_clk,
    input logic rst,
    input logic set,
    input logic clr,
    output logic flag
);

    logic flag_reg;
    logic flag_next;

    // set is tested first so a same-cycle event survives the clear
    assign flag_next = set ? 1'b1 : (clr ? 1'b0 : flag_reg);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flag_reg <= DCF_FLAG_RST;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

endmodule

// >>> verilog/dcf_pkg.sv
// constants and carrier types for the channel 5/6 event flag bank
// assumes one 125 MHz clock shared with the transfer engine and bus master
package dcf_pkg;

    localparam int DCF_ADDR_W = 8;
    localparam int DCF_DATA_W = 32;
    localparam int DCF_NUM_FLAGS = 6;

    localparam logic [DCF_ADDR_W-1:0] DCF_STATUS_OFF = 8'h00;
    localparam logic [DCF_ADDR_W-1:0] DCF_CLEAR_OFF = 8'h04;

    // flag positions, shared by the status and the clear register
    localparam int DCF_CH5_HALF_BIT = 22;
    localparam int DCF_CH5_ERR_BIT = 23;
    localparam int DCF_CH6_ANY_BIT = 24;
    localparam int DCF_CH6_DONE_BIT = 25;
    localparam int DCF_CH6_HALF_BIT = 26;
    localparam int DCF_CH6_ERR_BIT = 27;
    localparam int DCF_CH5_ALL_CLR_BIT = 20;
    localparam int DCF_CH6_ALL_CLR_BIT = 24;

    localparam logic DCF_FLAG_RST = 1'b0;
    localparam logic [DCF_DATA_W-1:0] DCF_RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic [DCF_ADDR_W-1:0] addr;
        logic [DCF_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } dcf_bus_req_t;

    typedef struct packed {
        logic half;
        logic error;
    } dcf_ch5_ev_t;

    typedef struct packed {
        logic done;
        logic half;
        logic error;
    } dcf_ch6_ev_t;

endpackage
